// ---- hw/dmac_pkg.sv ----
// Notes on behaviour
// - indirect upper addresses reach upper ram
// - external_select clear: moves reach expanded ram
// - expanded ram access leaves ports undisturbed
// - pointer moves above size use external bus
// - above 256 bytes only via data pointer
// - external select set: 8-bit register address
// - external select set: 16-bit pointer address
// - low write and read strobes on bus
// - stack stays in internal 256-byte ram
// - strobes last 6 or 30 clocks
// - size field picks 256 to 1024 bytes
// - external select loaded from security byte
// - latch enable free-runs when control clear
// - latch control set: latch enable pulses only on moves
// - reset clears stretch, size, latch control
package dmac_pkg;
    // ------------------------------------------------
    // register map
    // ------------------------------------------------
    localparam logic [7:0] DMAC_AUX_ADDR = 8'h8e;
    localparam int DMAC_BIT_STRETCH = 5;
    localparam int DMAC_BIT_XSIZE_HI = 3;
    localparam int DMAC_BIT_XSIZE_LO = 2;
    localparam int DMAC_BIT_EXTSEL = 1;
    localparam int DMAC_BIT_LATCH = 0;
    localparam logic [7:0] DMAC_AUX_WMASK = 8'h2f;
    localparam logic [7:0] DMAC_IRAM_UPPER = 8'h80;
    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam int DMAC_STROBE_SHORT = 6;
    localparam int DMAC_STROBE_LONG = 30;
    localparam int DMAC_LATCH_DIV_STD = 6;
    localparam int DMAC_LATCH_DIV_FAST = 3;
    localparam int DMAC_ADDR_PHASE = 2;
    localparam int DMAC_CNT_W = 5;
    // ------------------------------------------------
    // state machine
    // ------------------------------------------------
    typedef enum logic [1:0] {
        DMAC_IDLE,
        DMAC_ADDR,
        DMAC_STROBE,
        DMAC_HOLD
    } dmac_state_t;
endpackage

// ---- hw/dmac_onchip_expanded_ram.sv ----
`timescale 1ns/1ps
module dmac_onchip_expanded_ram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    // write and registered read
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ---- hw/dmac_top.sv ----
`timescale 1ns/1ps
module dmac_top
    import dmac_pkg::*;
#(
    parameter int ONCHIP_EXPANDED_RAM_DEPTH = 1024,
    parameter int ONCHIP_EXPANDED_RAM_AW = 10
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsb_extsel,
    input wire logic fast_clock_mode,
    // special function register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // internal ram steering
    input wire logic iram_indirect,
    input wire logic iram_stack,
    input wire logic [7:0] iram_addr,
    output logic iram_upper_sel,
    output logic sfr_space_sel,
    // core move request
    input wire logic mv_req,
    input wire logic mv_write,
    input wire logic mv_use_data_pointer,
    input wire logic code_read_move,
    input wire logic [7:0] mv_reg_addr,
    input wire logic [7:0] data_pointer_high,
    input wire logic [7:0] data_pointer_low,
    input wire logic [7:0] mv_wdata,
    output logic mv_busy,
    output logic mv_done,
    output logic [7:0] mv_rdata,
    // external bus pins
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic port_zero_oe_n,
    output logic [7:0] port_two_out,
    output logic port_two_bus,
    output logic wr_strobe_n,
    output logic rd_strobe_n,
    output logic addr_latch_en
);
    import dmac_pkg::*;

    // ------------------------------------------------
    // aux memory control register
    // ------------------------------------------------
    logic [7:0] aux_r;
    logic strap_done_r;
    wire aux_sel = (sfr_addr == DMAC_AUX_ADDR);
    wire aux_we = sfr_wr && aux_sel;
    // field taps of the control register
    wire strobe_stretch = aux_r[DMAC_BIT_STRETCH];
    wire xsize_bit_high = aux_r[DMAC_BIT_XSIZE_HI];
    wire xsize_bit_low = aux_r[DMAC_BIT_XSIZE_LO];
    wire external_select = aux_r[DMAC_BIT_EXTSEL];
    wire latch_pulse_control = aux_r[DMAC_BIT_LATCH];

    // reset clears fields, strap loaded after release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aux_r <= 8'h00;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            aux_r[DMAC_BIT_EXTSEL] <= hsb_extsel;
            strap_done_r <= 1'b1;
        end else if (aux_we) begin
            aux_r <= sfr_wdata & DMAC_AUX_WMASK;
        end
    end

    // read back with reserved bits zero
    assign sfr_hit = aux_sel && (sfr_rd || sfr_wr);
    assign sfr_rdata = (sfr_rd && aux_sel) ? (aux_r & DMAC_AUX_WMASK) : 8'h00;

    // ------------------------------------------------
    // internal ram steering
    // ------------------------------------------------
    // indirect and stack accesses never reach sfr space
    wire iram_high = iram_addr >= DMAC_IRAM_UPPER;
    assign iram_upper_sel = iram_high && (iram_indirect || iram_stack);
    assign sfr_space_sel = iram_high && !iram_indirect && !iram_stack;

    // ------------------------------------------------
    // move decode
    // ------------------------------------------------
    logic [10:0] xsize_bytes;
    always_comb begin
        unique case ({xsize_bit_high, xsize_bit_low})
            2'b00: xsize_bytes = 11'h100;
            2'b01: xsize_bytes = 11'h200;
            2'b10: xsize_bytes = 11'h300;
            2'b11: xsize_bytes = 11'h400;
        endcase
    end
    wire [15:0] data_pointer = {data_pointer_high, data_pointer_low};
    // register form reaches only the first 256 bytes
    wire [15:0] mv_addr = mv_use_data_pointer ? data_pointer : {8'h00, mv_reg_addr};
    wire in_onchip_expanded_ram = !external_select && (mv_addr < {5'h00, xsize_bytes});
    wire go_onchip_expanded_ram = mv_req && !mv_busy && in_onchip_expanded_ram;
    wire go_ext = mv_req && !mv_busy && !in_onchip_expanded_ram;

    // ------------------------------------------------
    // on-chip expanded ram
    // ------------------------------------------------
    logic [7:0] onchip_expanded_ram_rdata;
    logic onchip_expanded_ram_rd_r;
    logic onchip_expanded_ram_load_r;
    dmac_onchip_expanded_ram #(
        .DEPTH(ONCHIP_EXPANDED_RAM_DEPTH),
        .AW(ONCHIP_EXPANDED_RAM_AW)
    ) u_onchip_expanded_ram (
        .mclk(mclk),
        .wr_en(go_onchip_expanded_ram && mv_write),
        .addr(mv_addr[ONCHIP_EXPANDED_RAM_AW-1:0]),
        .wdata(mv_wdata),
        .rdata(onchip_expanded_ram_rdata)
    );

    // ------------------------------------------------
    // external bus cycle
    // ------------------------------------------------
    dmac_state_t state_r, state_nxt;
    logic [DMAC_CNT_W-1:0] cnt_r;
    logic [15:0] ext_addr_r;
    logic ext_data_pointer_r, ext_write_r;
    logic [7:0] ext_wdata_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic [7:0] p0_in_s1_r, p0_in_s2_r;
    wire [DMAC_CNT_W-1:0] strobe_len = strobe_stretch ? DMAC_CNT_W'(DMAC_STROBE_LONG)
                                                      : DMAC_CNT_W'(DMAC_STROBE_SHORT);
    wire cnt_end = (cnt_r == DMAC_CNT_W'(1));

    // bus sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DMAC_IDLE: if (go_ext) state_nxt = DMAC_ADDR;
            DMAC_ADDR: if (cnt_end) state_nxt = DMAC_STROBE;
            DMAC_STROBE: if (cnt_end) state_nxt = DMAC_HOLD;
            DMAC_HOLD: state_nxt = DMAC_IDLE;
        endcase
    end

    // sequencer state and phase counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= DMAC_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == DMAC_IDLE && go_ext) begin
                cnt_r <= DMAC_CNT_W'(DMAC_ADDR_PHASE);
            end else if (state_r == DMAC_ADDR && cnt_end) begin
                cnt_r <= strobe_len;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - DMAC_CNT_W'(1);
            end
        end
    end

    // capture the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_addr_r <= 16'h0000;
            ext_data_pointer_r <= 1'b0;
            ext_write_r <= 1'b0;
            ext_wdata_r <= 8'h00;
        end else if (go_ext) begin
            ext_addr_r <= mv_addr;
            ext_data_pointer_r <= mv_use_data_pointer;
            ext_write_r <= mv_write;
            ext_wdata_r <= mv_wdata;
        end
    end

    // port zero input synchroniser
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p0_in_s1_r <= 8'h00;
            p0_in_s2_r <= 8'h00;
        end else begin
            p0_in_s1_r <= port_zero_in;
            p0_in_s2_r <= p0_in_s1_r;
        end
    end

    // on-chip move tracking and completion
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            onchip_expanded_ram_rd_r <= 1'b0;
            onchip_expanded_ram_load_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            onchip_expanded_ram_rd_r <= go_onchip_expanded_ram;
            onchip_expanded_ram_load_r <= go_onchip_expanded_ram && !mv_write; // writes keep the last read byte
            done_r <= onchip_expanded_ram_rd_r || (state_r == DMAC_HOLD);
        end
    end

    // read data from whichever side answered
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (onchip_expanded_ram_load_r) begin
            rdata_r <= onchip_expanded_ram_rdata;
        end else if (state_r == DMAC_HOLD && !ext_write_r) begin
            rdata_r <= p0_in_s2_r;
        end
    end
    assign mv_rdata = rdata_r;
    assign mv_done = done_r;
    assign mv_busy = (state_r != DMAC_IDLE) || onchip_expanded_ram_rd_r;

    // ------------------------------------------------
    // pin drive
    // ------------------------------------------------
    logic [7:0] p0_out_r, p2_out_r;
    logic p0_oe_n_r, p2_bus_r, wr_n_r, rd_n_r;
    // phase the sequencer enters at the next edge
    wire nxt_addr = (state_nxt == DMAC_ADDR);
    wire nxt_strobe = (state_nxt == DMAC_STROBE);
    wire nxt_hold = (state_nxt == DMAC_HOLD);
    // request fields, live while idle, latched once a cycle starts
    wire [15:0] nxt_a = (state_r == DMAC_IDLE) ? mv_addr : ext_addr_r;
    wire nxt_dp = (state_r == DMAC_IDLE) ? mv_use_data_pointer : ext_data_pointer_r;
    wire nxt_wr = (state_r == DMAC_IDLE) ? mv_write : ext_write_r;
    wire [7:0] nxt_wd = (state_r == DMAC_IDLE) ? mv_wdata : ext_wdata_r;
    wire nxt_active = nxt_addr || nxt_strobe || nxt_hold;

    // address and data pins, held while no bus cycle runs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p0_out_r <= 8'hff;
            p2_out_r <= 8'hff;
        end else if (nxt_active) begin
            p0_out_r <= nxt_addr ? nxt_a[7:0] : nxt_wd;
            p2_out_r <= nxt_a[15:8];
        end
    end

    // enables and strobes, untouched by on-chip accesses
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p0_oe_n_r <= 1'b1;
            p2_bus_r <= 1'b0;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
        end else begin
            p0_oe_n_r <= !(nxt_addr || (nxt_wr && (nxt_strobe || nxt_hold)));
            p2_bus_r <= nxt_active && nxt_dp;
            wr_n_r <= !(nxt_strobe && nxt_wr);
            rd_n_r <= !(nxt_strobe && !nxt_wr);
        end
    end
    assign port_zero_out = p0_out_r;
    assign port_zero_oe_n = p0_oe_n_r;
    assign port_two_out = p2_out_r;
    assign port_two_bus = p2_bus_r;
    assign wr_strobe_n = wr_n_r;
    assign rd_strobe_n = rd_n_r;

    // ------------------------------------------------
    // address latch enable
    // ------------------------------------------------
    logic [2:0] ale_cnt_r;
    logic ale_r;
    wire [2:0] ale_div = fast_clock_mode ? 3'(DMAC_LATCH_DIV_FAST) : 3'(DMAC_LATCH_DIV_STD);
    wire ale_wrap = (ale_cnt_r >= ale_div - 3'd1);

    // free-running divider or move-only pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ale_cnt_r <= 3'd0;
            ale_r <= 1'b0;
        end else begin
            ale_cnt_r <= ale_wrap ? 3'd0 : ale_cnt_r + 3'd1;
            if (latch_pulse_control) begin
                ale_r <= (nxt_addr && state_r == DMAC_IDLE) || code_read_move;
            end else begin
                ale_r <= ale_wrap;
            end
        end
    end
    assign addr_latch_en = ale_r;
endmodule

// ---- testbench/dmac_assertions.sv ----
`timescale 1ns/1ps
module dmac_chk
    import dmac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic fast_clock_mode,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic iram_indirect,
    input wire logic iram_stack,
    input wire logic [7:0] iram_addr,
    input wire logic iram_upper_sel,
    input wire logic sfr_space_sel,
    input wire logic mv_done,
    input wire logic port_zero_oe_n,
    input wire logic wr_strobe_n,
    input wire logic rd_strobe_n,
    input wire logic addr_latch_en
);
    logic [5:0] low_cnt_r;
    // counts edges with a strobe held low
    always_ff @(posedge mclk) begin
        if (!rst_n || (rd_strobe_n && wr_strobe_n)) low_cnt_r <= 6'h00;
        else low_cnt_r <= low_cnt_r + 6'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe_end;
        $rose(rd_strobe_n && wr_strobe_n);
    endsequence
    a_strobe_len: assert property (s_strobe_end |-> low_cnt_r == 6 || low_cnt_r == 30)
        else $error("strobe width wrong");
    a_strobe_excl: assert property (!(!rd_strobe_n && !wr_strobe_n))
        else $error("both strobes low");
    a_rd_release: assert property (!rd_strobe_n |-> port_zero_oe_n)
        else $error("port zero driven in read");
    a_wr_drive: assert property (!wr_strobe_n |-> !port_zero_oe_n)
        else $error("port zero idle in write");
    a_end_done: assert property (s_strobe_end |-> ##[1:2] mv_done)
        else $error("no done after strobe");
    a_hit_decode: assert property (sfr_hit == ((sfr_rd || sfr_wr) && sfr_addr == DMAC_AUX_ADDR))
        else $error("register hit wrong");
    a_rsv_zero: assert property (sfr_rd && sfr_addr == DMAC_AUX_ADDR |-> (sfr_rdata & 8'hd0) == 8'h00)
        else $error("reserved bits not zero");
    a_ale_space: assert property (addr_latch_en && !fast_clock_mode |=> !addr_latch_en [*5])
        else $error("latch pulses too close");
    a_upper_ram: assert property (iram_addr >= 8'h80 && (iram_indirect || iram_stack)
        |-> iram_upper_sel && !sfr_space_sel)
        else $error("upper ram not chosen");
endmodule
bind dmac_top dmac_chk chk_u (.*);

// ---- testbench/dmac_ext_mem.sv ----
`timescale 1ns/1ps
module dmac_ext_mem (
    input wire logic mclk,
    input wire logic [7:0] port_zero_out,
    input wire logic port_zero_oe_n,
    input wire logic [7:0] port_two_out,
    input wire logic port_two_bus,
    input wire logic wr_strobe_n,
    input wire logic rd_strobe_n,
    output logic [7:0] port_zero_in
);
    logic [7:0] mem [int];
    logic [15:0] a;
    logic [7:0] last = 8'h00;
    // latch address, store writes, remember last read byte
    always @(posedge mclk) begin
        if (!port_zero_oe_n && wr_strobe_n && rd_strobe_n) a <= {port_two_bus ? port_two_out : 8'h00, port_zero_out};
        if (!wr_strobe_n) mem[a] = port_zero_out;
        if (!rd_strobe_n) last <= mem[a];
    end
    // released bus shows inverse of last byte
    assign port_zero_in = rd_strobe_n ? ~last : mem[a];
endmodule

// ---- testbench/data_memory_access_control_tb_top.sv ----
`timescale 1ns/1ps
module data_memory_access_control_tb_top;
    logic mclk = 0, rst_n, hsb_extsel, fast_clock_mode, sfr_wr, sfr_rd, sfr_hit;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, iram_addr, mv_reg_addr, mv_wdata, mv_rdata;
    logic [7:0] data_pointer_high, data_pointer_low, port_zero_in, port_zero_out, port_two_out;
    logic iram_indirect, iram_stack, iram_upper_sel, sfr_space_sel, mv_req, mv_write, mv_use_data_pointer;
    logic code_read_move, mv_busy, mv_done, port_zero_oe_n, port_two_bus, wr_strobe_n, rd_strobe_n;
    logic addr_latch_en;
    int failures = 0, cmp_count = 0, cyc = 0, s, n;
    dmac_top dut_u (.*);
    dmac_ext_mem mem_u (.*);
    always #20 mclk = ~mclk;
    // ----------------
    // check tasks
    // ----------------
    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // register access, read compares at once
    task sfr(input logic w, input logic [7:0] a, d);
        sfr_wr = w;
        sfr_rd = !w;
        sfr_addr = a;
        sfr_wdata = d;
        #5;
        if (!w) chk("aux", sfr_rdata, d);
        @(negedge mclk);
        sfr_wr = 0;
        sfr_rd = 0;
        @(negedge mclk);
    endtask
    // one move; watches bus, strobe width, page byte
    task mv(input logic w, d, input logic [15:0] ad, input logic [7:0] wd, input logic ex, input int len);
        int k, lw;
        logic e, b;
        logic [7:0] p2;
        logic [15:0] pv;
        pv = {port_two_out, port_zero_out};
        {mv_write, mv_use_data_pointer, data_pointer_high, data_pointer_low, mv_wdata, mv_req} = {w, d, ad, wd, 1'b1};
        mv_reg_addr = ad[7:0];
        @(negedge mclk);
        mv_req = 0;
        chk("busy", mv_busy, 1'b1);
        {k, lw, e, b, p2} = 0;
        while (mv_done !== 1'b1 && k < 80) begin
            if (!rd_strobe_n || !wr_strobe_n) lw++;
            if (!port_zero_oe_n || !rd_strobe_n || !wr_strobe_n || port_two_bus) e = 1;
            if (port_two_bus) {b, p2} = {1'b1, port_two_out};
            @(negedge mclk);
            k++;
        end
        chk("done", k < 80, 1'b1);
        chk("ext", e, ex);
        if (!ex) chk("pins", {port_two_out, port_zero_out}, pv);
        chk("len", lw, ex ? len : 0);
        chk("p2bus", b, ex & d);
        if (b) chk("p2", p2, ad[15:8]);
        if (!w) chk("rdata", mv_rdata, wd);
    endtask
    always @(posedge mclk) if (++cyc == 20000) begin
        failures++;
        final_report;
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        {rst_n, hsb_extsel, fast_clock_mode, sfr_wr, sfr_rd, iram_indirect, iram_stack, mv_req} = 0;
        {mv_write, mv_use_data_pointer, code_read_move, mv_reg_addr, sfr_addr, sfr_wdata, iram_addr} = 0;
        {data_pointer_high, data_pointer_low, mv_wdata} = 0;
        for (s = 0; s < 2; s++) begin
            hsb_extsel = s[0];
            rst_n = 0;
            repeat (6) @(negedge mclk);
            rst_n = 1;
            repeat (2) @(negedge mclk);
            sfr(0, 8'h8e, s ? 8'h02 : 8'h00);
        end
        sfr(1, 8'h8e, 8'h2d);
        sfr(0, 8'h8e, 8'h2d);
        sfr(0, 8'h8f, 8'h00);
        for (s = 0; s < 4; s++) begin
            sfr(1, 8'h8e, 8'(s << 2));
            mv(1, 1, 16'((s + 1) * 256 - 1), 8'(s + 1), 0, 0);
            mv(0, 1, 16'((s + 1) * 256 - 1), 8'(s + 1), 0, 0);
            mv(1, 1, 16'((s + 1) * 256), 8'(s + 8'h40), 1, 6);
            mv(0, 1, 16'((s + 1) * 256), 8'(s + 8'h40), 1, 6);
        end
        $display("size test done");
        mv(1, 1, 16'h01a0, 8'h77, 0, 0);
        mv(1, 0, 16'h01a0, 8'h33, 0, 0);
        mv(0, 1, 16'h00a0, 8'h33, 0, 0);
        mv(0, 1, 16'h01a0, 8'h77, 0, 0);
        sfr(1, 8'h8e, 8'h02);
        mv(1, 0, 16'h0034, 8'h5c, 1, 6);
        mv(0, 0, 16'h0034, 8'h5c, 1, 6);
        mv(1, 1, 16'h0210, 8'h6d, 1, 6);
        sfr(1, 8'h8e, 8'h22);
        mv(0, 1, 16'h0210, 8'h6d, 1, 30);
        $display("bus test done");
        for (s = 0; s < 3; s++) begin
            fast_clock_mode = (s == 2);
            sfr(1, 8'h8e, (s == 1) ? 8'h01 : 8'h00);
            repeat (6) @(negedge mclk);
            n = 0;
            code_read_move = (s == 1);
            repeat (24) begin
                @(negedge mclk);
                n += addr_latch_en;
                code_read_move = 0;
            end
            chk("ale", n, (s == 1) ? 1 : 4 + 2 * s);
        end
        for (s = 0; s < 3; s++) begin
            {iram_indirect, iram_stack, iram_addr} = {s == 0, s == 1, 8'ha0};
            #5 chk("upper", {iram_upper_sel, sfr_space_sel}, s < 2 ? 2'b10 : 2'b01);
            @(negedge mclk);
        end
        $display("latch and ram test done");
        final_report;
    end
endmodule
